//--- rtl/sysbus_consts.svh
// sysbus_consts.svh: offsets, field positions, codes and counts for the request/error block
// assumes: included by bare name from the package and the design module
`ifndef SYSBUS_CONSTS_SVH
`define SYSBUS_CONSTS_SVH
`define ERR_PHASE_DLY 3
`define WIRED_ASSERT_CLKS 2'd3
`define WIRED_BACKOFF_CLKS 2'd2
`define ASZ_LSB 3
`define ASZ_BELOW_4G 2'h0
`define ASZ_4G_TO_64G 2'h1
`define ATTR_LSB 24
`define BE_LSB 8
`define SPECIAL_REQ_FIRST 5'h08
`define SPECIAL_REQ_SECOND 2'h1
`define SPC_SMI_ACK 8'h07
`define RESET_ROT_ID 2'h3
`endif

//--- rtl/sysbus_pkg.sv
// sysbus_pkg.sv: types shared by the request/error block
// assumes: constants come from sysbus_consts.svh
`default_nettype none
`include "sysbus_consts.svh"
package sysbus_pkg;
  // request sampled on the bus in true (active-high) sense, parity kept at raw pin level
  typedef struct packed {
    logic strobe;
    logic [35:3] addr;
    logic [4:0] code;
    logic [1:0] parity;
  } req_t;
  // decoded view of one request
  typedef struct packed {
    logic is_mem;
    logic addr_space_ok;
    logic [4:0] mem_type_attr;
    logic [7:0] byte_lane_enable;
    logic is_special;
    logic [7:0] special_code;
    logic special_valid;
  } decode_t;
  typedef enum logic [2:0] {
    WIRE_IDLE = 3'h1,
    WIRE_DRIVE = 3'h2,
    WIRE_BACKOFF = 3'h4
  } wire_state_t;
  typedef enum logic [1:0] {
    CLK_X2 = 2'h0,
    CLK_X3 = 2'h1,
    CLK_X4 = 2'h2
  } core_ratio_t;
endpackage : sysbus_pkg
`default_nettype wire

//--- rtl/sysbus_request_attr_error.sv
// sysbus_request_attr_error.sv: request-phase parity check, attribute and byte-enable decode,
// address-error drive in the error phase, wired bus-error and bus-initialize drivers.
// assumes: bus pins arrive asynchronously and are synchronised here; the initiator keeps the
// strobe for one clock and the rest of the request for two; outputs are true-sense enables.
// Function
// - upper parity covers 35:24, lower 23:3
// - parity high for even low count
// - parity error asserts address error when enabled
// - size field on code 4:3, memory only
// - 32-bit agents accept 00, 36-bit 00/01
// - attribute on second-clock 31:24, 7:3 zero
// - everything on rising bus clock edge
// - core clock ratio 2, 3 or 4
// - byte enable n validates lane n
// - special transactions carry cycle codes
// - enables undefined for reply, ack, trace
// - bus error asserted three clocks after idle
// - bus error backs off after two clocks; this driver never enters back-off, since its line_prev input is tied high
// - bus error driver configurable sources
// - bus error input never sampled
// - bus init drive three clocks, back off; this driver never enters back-off, since mine is high throughout its drive
// - bus init observation resets bus state
// - bus init ignored when observation off
// - error phase three clocks after request
`default_nettype none
`include "sysbus_consts.svh"
module sysbus_request_attr_error (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  input wire logic i_req_strobe_n,
  input wire logic [35:3] i_addr_n,
  input wire logic [4:0] i_req_code_n,
  input wire logic [1:0] i_addr_parity_n,
  input wire logic i_bus_init_n,
  input wire logic i_addr_err_drive_en,
  input wire logic i_addr_36bit,
  input wire logic i_bus_err_n_drive_en,
  input wire logic i_bus_err_n_on_internal,
  input wire logic i_bus_err_n_on_initiator,
  input wire logic i_bus_err_n_on_any,
  input wire logic i_bus_init_n_drive_en,
  input wire logic i_bus_init_n_observe_en,
  input wire logic i_internal_err,
  input wire logic i_txn_err,
  input wire logic i_is_initiator,
  input wire logic i_bus_init_n_err,
  input wire sysbus_pkg::core_ratio_t i_core_ratio,
  output logic o_addr_err_oe,
  output logic o_bus_err_oe,
  output logic o_bus_init_oe,
  output logic o_internal_err_n,
  output logic o_bus_reset,
  output logic [1:0] o_rot_id,
  output logic [2:0] o_core_mult,
  output logic o_req_accept,
  output sysbus_pkg::decode_t o_decode
);
  import sysbus_pkg::*;

  // timing of one request, counted from the edge E that first sees the strobe pin low:
  //   E     strobe and first-clock pins enter sync1
  //   E+1   first clock reaches sync2; code, address and parity are kept on the next edge
  //   E+2   first_clk set while the second request clock sits in sync2
  //   E+3   decode, accept pulse and the parity verdict of both clocks are registered
  //   E+5   address-error enable drives its wire for exactly one clock
  // the two synchroniser stages are the price of taking raw pins; the error phase is
  // therefore placed relative to the synchronised strobe, not the pin itself.
  // a new request may follow every three clocks; the pipe below has one slot per clock,
  // so back-to-back requests never share an error-phase slot.
  //
  // wired lines (bus error, bus init):
  //   a cause is taken only while the line is idle and our own driver is idle
  //   a drive lasts three clocks; a cause that arrives during it is dropped
  //   bus error is never sampled, so its driver tracks only its own drive
  //   bus init is sampled through two flops, so our own assertion shows two clocks late
  //
  // observed bus init resets the request pipe and the rotating id, but leaves the
  // wired-line drivers alone so that a drive in progress still completes its length.
  //
  // limitation: the rotating id only ever holds its reset value here; the arbitration
  // that moves it lives outside this block.
  //
  // every output is a field of the state register, so all outputs leave a flop.

  typedef struct packed {
    req_t sync1;
    req_t sync2;
    logic [1:0] bus_init_n_s1;
    logic [1:0] bus_init_n_s2;
    logic bus_init_n_prev;
    logic first_clk;
    logic [4:0] code_first;
    logic [35:3] addr_first;
    logic perr_first;
    logic [`ERR_PHASE_DLY-1:0] err_pipe;
    logic addr_err;
    wire_state_t bus_err_n_st;
    logic [1:0] bus_err_n_cnt;
    wire_state_t bus_init_n_st;
    logic [1:0] bus_init_n_cnt;
    logic bus_err;
    logic bus_init;
    logic internal_err_n;
    logic bus_reset;
    logic [1:0] rot_id;
    logic [2:0] core_mult;
    logic req_accept;
    decode_t dec;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // a is true sense (one per low pin); a good parity pin is high for an even count of ones
  function automatic logic par_bad(input logic [35:3] a, input logic [1:0] p);
    par_bad = ((~^a[35:24]) != p[1]) || ((~^a[23:3]) != p[0]);
  endfunction : par_bad

  // one wired-or driver step; the same logic serves bus error and bus init
  function automatic logic [4:0] wire_step(input wire_state_t st, input logic [1:0] cnt,
                                           input logic cause, input logic line,
                                           input logic line_prev, input logic mine);
    wire_state_t ns;
    logic [1:0] nc;
    ns = st;
    nc = cnt;
    case (st)
      WIRE_IDLE: begin
        if (cause && !line) begin
          ns = WIRE_DRIVE;
          nc = `WIRED_ASSERT_CLKS - 2'd1;
        end
      end
      WIRE_DRIVE: begin
        if (line_prev == 1'b0 && line && !mine) begin
          ns = WIRE_BACKOFF;
          nc = `WIRED_BACKOFF_CLKS - 2'd1;
        end else if (cnt == 2'd0) begin
          ns = WIRE_IDLE;
        end else begin
          nc = cnt - 2'd1;
        end
      end
      WIRE_BACKOFF: begin
        if (cnt == 2'd0) begin
          ns = WIRE_IDLE;
        end else begin
          nc = cnt - 2'd1;
        end
      end
      default: begin
        ns = WIRE_IDLE;
        nc = 2'd0;
      end
    endcase
    wire_step = {ns, nc};
  endfunction : wire_step

  // decode one request from both request clocks; undefined fields are forced to zero
  function automatic decode_t decode_req(input logic [4:0] code_a, input logic [1:0] code_b,
                                         input logic [35:3] addr_b, input logic wide_space);
    decode_t d;
    logic [1:0] asz;
    logic [7:0] lanes;
    d = '0;
    asz = code_a[`ASZ_LSB+1:`ASZ_LSB];
    lanes = addr_b[`BE_LSB+7:`BE_LSB];
    d.is_mem = code_a[1:0] != 2'h0;
    // a 32-bit agent takes only the low space; reserved sizes are never ours
    d.addr_space_ok = (asz == `ASZ_BELOW_4G)
                      || (wide_space && asz == `ASZ_4G_TO_64G);
    // reserved attribute bits read as zero whatever the initiator drove
    d.mem_type_attr = {2'h0, addr_b[`ATTR_LSB+2:`ATTR_LSB]};
    d.is_special = code_a == `SPECIAL_REQ_FIRST && code_b == `SPECIAL_REQ_SECOND;
    // lanes mean data only for memory and io; reply, ack and trace leave them undefined
    if (d.is_mem || code_a[4:1] == 4'h8) begin
      d.byte_lane_enable = lanes;
    end
    if (d.is_special) begin
      d.special_code = lanes;
      d.special_valid = lanes != 8'h00 && lanes <= `SPC_SMI_ACK;
    end
    decode_req = d;
  endfunction : decode_req

  // next-state logic; sampled request is the second sync stage only
  always_comb begin
    req_t cur;
    logic bus_err_n_cause;
    logic line_bus_init_n;
    logic [4:0] bs;
    logic [4:0] is;
    cur = state_r.sync2;
    bus_err_n_cause = 1'b0;
    line_bus_init_n = 1'b0;
    bs = 5'h00;
    is = 5'h00;
    state_nxt = state_r;
    // pins are active low; all but parity invert into true sense before the first flop
    state_nxt.sync1 = '{strobe: !i_req_strobe_n, addr: ~i_addr_n, code: ~i_req_code_n,
                        parity: i_addr_parity_n};
    state_nxt.sync2 = state_r.sync1;
    state_nxt.bus_init_n_s1 = {1'b0, !i_bus_init_n};
    state_nxt.bus_init_n_s2 = state_r.bus_init_n_s1;
    line_bus_init_n = state_r.bus_init_n_s2[0];
    state_nxt.bus_init_n_prev = line_bus_init_n;
    // address is kept in true sense; the parity pins stay at their raw level
    state_nxt.first_clk = cur.strobe;
    state_nxt.req_accept = 1'b0;
    state_nxt.err_pipe = {state_r.err_pipe[`ERR_PHASE_DLY-2:0], 1'b0};
    if (cur.strobe) begin
      state_nxt.code_first = cur.code;
      state_nxt.addr_first = cur.addr;
      state_nxt.perr_first = par_bad(cur.addr, cur.parity);
    end
    // second request clock: decode both clocks together
    if (state_r.first_clk) begin
      state_nxt.dec = decode_req(state_r.code_first, cur.code[1:0], cur.addr, i_addr_36bit);
      state_nxt.req_accept = !state_nxt.dec.is_mem || state_nxt.dec.addr_space_ok;
      // error in either request clock counts
      state_nxt.err_pipe[0] = i_addr_err_drive_en
        && (state_r.perr_first || par_bad(cur.addr, cur.parity));
    end
    // strobe seen at pipe entry one cycle late, so error phase lands third clock
    state_nxt.addr_err = state_r.err_pipe[`ERR_PHASE_DLY-2];
    // bus error is only driven, its line is tracked from our own drive
    bus_err_n_cause = i_bus_err_n_drive_en && ((i_bus_err_n_on_internal && i_internal_err)
      || (i_bus_err_n_on_initiator && i_is_initiator && i_txn_err)
      || (i_bus_err_n_on_any && i_txn_err));
    bs = wire_step(state_r.bus_err_n_st, state_r.bus_err_n_cnt, bus_err_n_cause, state_r.bus_err, 1'b1, 1'b1);
    state_nxt.bus_err_n_st = wire_state_t'(bs[4:2]);
    state_nxt.bus_err_n_cnt = bs[1:0];
    state_nxt.bus_err = state_nxt.bus_err_n_st == WIRE_DRIVE;
    state_nxt.internal_err_n = !(i_bus_err_n_on_internal && i_internal_err);
    is = wire_step(state_r.bus_init_n_st, state_r.bus_init_n_cnt, i_bus_init_n_drive_en && i_bus_init_n_err,
                   line_bus_init_n, state_r.bus_init_n_prev, state_r.bus_init);
    state_nxt.bus_init_n_st = wire_state_t'(is[4:2]);
    state_nxt.bus_init_n_cnt = is[1:0];
    state_nxt.bus_init = state_nxt.bus_init_n_st == WIRE_DRIVE;
    // observed bus init clears the bus machines but not the drivers of the wired lines
    state_nxt.bus_reset = i_bus_init_n_observe_en && line_bus_init_n;
    if (state_nxt.bus_reset) begin
      state_nxt.rot_id = `RESET_ROT_ID;
      state_nxt.err_pipe = '0;
      state_nxt.first_clk = 1'b0;
      state_nxt.addr_err = 1'b0;
    end
    case (i_core_ratio)
      CLK_X2: state_nxt.core_mult = 3'h2;
      CLK_X3: state_nxt.core_mult = 3'h3;
      CLK_X4: state_nxt.core_mult = 3'h4;
      default: state_nxt.core_mult = 3'h2;
    endcase
  end

  // single state register, rising edge only, frozen by clock enable
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state_r <= '0;
      state_r.bus_err_n_st <= WIRE_IDLE;
      state_r.bus_init_n_st <= WIRE_IDLE;
      state_r.internal_err_n <= 1'b1;
      state_r.rot_id <= `RESET_ROT_ID;
      state_r.core_mult <= 3'h2;
    end else if (i_clk_en) begin
      state_r <= state_nxt;
    end
  end

  assign o_addr_err_oe = state_r.addr_err;
  assign o_bus_err_oe = state_r.bus_err;
  assign o_bus_init_oe = state_r.bus_init;
  assign o_internal_err_n = state_r.internal_err_n;
  assign o_bus_reset = state_r.bus_reset;
  assign o_rot_id = state_r.rot_id;
  assign o_core_mult = state_r.core_mult;
  assign o_req_accept = state_r.req_accept;
  assign o_decode = state_r.dec;
endmodule : sysbus_request_attr_error
`default_nettype wire

//--- tb/sysbus_checks_assertions.sv
// sysbus_checks_assertions.sv: output timing checks for the request/error block
// assumes: bound onto the block, one clock, synchronous low reset
`default_nettype none
module sysbus_checks (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_addr_err_drive_en,
  input wire logic i_bus_err_n_drive_en,
  input wire sysbus_pkg::core_ratio_t i_core_ratio,
  input wire logic o_addr_err_oe,
  input wire logic o_bus_err_oe,
  input wire logic o_bus_init_oe,
  input wire logic o_bus_reset,
  input wire logic [1:0] o_rot_id,
  input wire logic [2:0] o_core_mult,
  input wire logic o_req_accept
);
  import sysbus_pkg::*;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);
  // lone pulse, then two quiet clocks so the next error phase is distinct
  addr_err_n_pulse_a: assert property (o_addr_err_oe |=> !o_addr_err_oe [*2])
    else $error("addr_err_n pulse");
  addr_err_n_gate_a: assert property (o_addr_err_oe |-> i_addr_err_drive_en)
    else $error("addr_err_n gate");
  bus_err_n_len_a: assert property ($rose(o_bus_err_oe) |=>
    o_bus_err_oe[*2] ##1 !o_bus_err_oe) else $error("bus_err_n length");
  bus_err_n_gate_a: assert property (!i_bus_err_n_drive_en [*4] |-> !o_bus_err_oe)
    else $error("bus_err_n gate");
  // our own drive never backs off and always lasts three clocks; the window also admits two
  bus_init_n_len_a: assert property ($rose(o_bus_init_oe) |=>
    o_bus_init_oe ##[1:2] !o_bus_init_oe) else $error("bus_init_n length");
  accept_pulse_a: assert property (o_req_accept |=> !o_req_accept)
    else $error("accept pulse");
  rot_reset_a: assert property (o_bus_reset |-> ##[0:1] o_rot_id == 2'h3)
    else $error("rot id");
  core_mult_a: assert property ($stable(i_core_ratio) [*3] |->
    o_core_mult == 3'(i_core_ratio) + 3'h2) else $error("core mult");
  cover property ($rose(o_bus_err_oe));
  cover property (o_addr_err_oe);
  cover property (o_bus_reset);
endmodule : sysbus_checks
bind sysbus_request_attr_error sysbus_checks u_checks (.*);
`default_nettype wire

//--- tb/sysbus_initiator_model.sv
// sysbus_initiator_model.sv: far-side request initiator plus another agent on the init wire
// assumes: bus lines are pulled up, so released lines read high
`default_nettype none
module sysbus_initiator_model (
  input wire logic i_clock,
  input wire logic i_go,
  input wire logic [35:3] i_a1_n,
  input wire logic [35:3] i_a2_n,
  input wire logic [4:0] i_c1_n,
  input wire logic [4:0] i_c2_n,
  input wire logic [1:0] i_bad,
  input wire logic i_other_init,
  input wire logic i_own_init_oe,
  output logic o_strobe_n = 1'b1,
  output logic [35:3] o_addr_n = '1,
  output logic [4:0] o_code_n = '1,
  output logic [1:0] o_parity_n = '1,
  output logic o_bus_init_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic second = 1'b0;
  // a good parity bit is high when the count of low pins it covers is even
  function automatic logic [1:0] par(input logic [35:3] a);
    return {~^(~a[35:24]), ~^(~a[23:3])};
  endfunction : par
  // strobe one clock, the rest two; afterwards the lines float to the pull-up
  always @(posedge i_clock) begin
    second <= i_go;
    o_strobe_n <= !i_go;
    o_addr_n <= i_go ? i_a1_n : second ? i_a2_n : '1;
    o_code_n <= i_go ? i_c1_n : second ? i_c2_n : '1;
    o_parity_n <= i_go ? par(i_a1_n) ^ i_bad : second ? par(i_a2_n) : '1;
  end
  // wired line: low while any agent drives it
  assign o_bus_init_n = !(i_other_init | i_own_init_oe);
endmodule : sysbus_initiator_model
`default_nettype wire

//--- tb/sysbus_request_attr_error_tb.sv
// sysbus_request_attr_error_tb.sv: self-checking bench for the request/error block
// assumes: the initiator model drives the pins; results matched from a note queue
`default_nettype none
module sysbus_request_attr_error_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sysbus_pkg::*;
  typedef struct {decode_t d, m; logic ac, ae, er;} note_t;
  note_t notes[$], cur;
  logic clk = 0, nrst = 0, go = 0, aee = 0, a36 = 0, ben = 0, bany = 0, bint = 0;
  logic bdrv = 0, bobs = 0, ie = 0, te = 0, be2 = 0, oth = 0, sa = 0, se = 0;
  logic [35:3] a1 = '1, a2 = '1;
  logic [4:0] c1 = '1, c2 = '1;
  logic [1:0] bad = 0, fl = 0;
  logic [3:0] bc = 0, ic = 0;
  logic [6:0] sh = 0;
  core_ratio_t cr = CLK_X2;
  int seed = 32'h30F0, num_errors = 0, total_checks = 0;
  wire logic stb_n, bi_n, aoe, boe, ioe, ien, brst, acw;
  wire logic [35:3] ad_n;
  wire logic [4:0] cd_n;
  wire logic [1:0] p_n, rot;
  wire decode_t dec;
  sysbus_initiator_model u_init (.i_clock(clk), .i_go(go), .i_a1_n(a1), .i_a2_n(a2),
    .i_c1_n(c1), .i_c2_n(c2), .i_bad(bad), .i_other_init(oth), .i_own_init_oe(ioe),
    .o_strobe_n(stb_n), .o_addr_n(ad_n), .o_code_n(cd_n), .o_parity_n(p_n), .o_bus_init_n(bi_n));
  sysbus_request_attr_error u_dut (.i_clock(clk), .i_nrst(nrst), .i_clk_en(1'b1),
    .i_req_strobe_n(stb_n), .i_addr_n(ad_n), .i_req_code_n(cd_n), .i_addr_parity_n(p_n),
    .i_bus_init_n(bi_n), .i_addr_err_drive_en(aee), .i_addr_36bit(a36), .i_bus_err_n_drive_en(ben),
    .i_bus_err_n_on_internal(bint), .i_bus_err_n_on_initiator(bint), .i_bus_err_n_on_any(bany),
    .i_bus_init_n_drive_en(bdrv), .i_bus_init_n_observe_en(bobs), .i_internal_err(ie), .i_txn_err(te),
    .i_is_initiator(bint), .i_bus_init_n_err(be2), .i_core_ratio(cr), .o_addr_err_oe(aoe),
    .o_bus_err_oe(boe), .o_bus_init_oe(ioe), .o_internal_err_n(ien), .o_bus_reset(brst),
    .o_rot_id(rot), .o_core_mult(), .o_req_accept(acw), .o_decode(dec));
  initial forever #10 clk = ~clk;
  // drive lengths and sticky flags; gated so reset-time unknowns never latch
  always @(posedge clk) if (nrst) begin
    bc <= bc + 4'(boe);
    ic <= ic + 4'(ioe);
    fl <= fl | {brst, !ien};
  end
  task automatic check(input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  // watcher: the answer lands a few clocks behind the strobe, so a window absorbs sync skew
  always @(negedge clk) begin
    sh = {sh[5:0], !stb_n};
    if (sh[3]) begin
      cur = notes.pop_front();
      sa = 0;
      se = 0;
    end
    sa = sa | (acw & |sh[5:3]);
    se = se | (aoe & |sh[6:4]);
    if (sh[5] && sa) check(dec & cur.m, cur.d & cur.m);
    if (sh[5] && cur.ac) check(sa, cur.ae);
    if (sh[6]) check(se, cur.er);
  end
  // note the expected decode first, then hand both request clocks to the model
  task automatic req(input logic [4:0] c, input logic [1:0] q, input logic [7:0] b,
                     input logic [1:0] x);
    logic [2:0] t;
    note_t n;
    t = 3'($random(seed));
    n.d = '{c[1:0] != 0, a36 ? !c[4] : c[4:3] == 0, {2'h0, t}, b, c == 5'h08 && q == 2'h1, b,
           b inside {[1:7]}};
    n.m = '{1'b1, n.d.is_mem, 5'h1F, {8{n.d.is_mem}}, 1'b1, {8{n.d.is_special}},
           n.d.is_special};
    n.ac = n.d.is_mem;
    n.ae = n.d.addr_space_ok;
    n.er = aee && x != 0;
    notes.push_back(n);
    a1 <= ~{3'h0, c[3], 29'($random(seed))};
    a2 <= ~{9'h0, t, 8'($random(seed)), b, 5'($random(seed))};
    c1 <= ~c;
    c2 <= ~{3'h0, q};
    bad <= x;
    cr <= core_ratio_t'(2'(t % 3));
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : req
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    aee <= 1'b1;
    @(posedge clk);
    // special codes 0..8, interrupt ack, deferred, io, then memory sizes
    for (int i = 0; i < 20; i++) begin
      if (i == 16 || i == 19) begin
        repeat (4) @(posedge clk);
        a36 <= 1'b1;
        aee <= (i == 16);
        @(posedge clk);
      end
      req(i < 10 ? 5'h08 : i == 10 ? 5'h00 : i == 11 ? 5'h10 : {2'(i % 3), i[0] ? 3'h3 : 3'h6},
          (i == 9) ? 2'h0 : 2'h1, i < 9 ? 8'(i) : 8'($random(seed)), {i == 13, i == 5 || i > 17});
    end
    ben <= 1'b1;
    bany <= 1'b1;
    te <= 1'b1;
    @(posedge clk) te <= 1'b0;
    repeat (8) @(posedge clk);
    check(bc, 4'h3);
    bint <= 1'b1;
    ie <= 1'b1;
    @(posedge clk) ie <= 1'b0;
    repeat (8) @(posedge clk);
    check({bc, fl}, {4'h6, 2'h1});
    // any-agent source off: only the initiator source can take this error
    bany <= 1'b0;
    te <= 1'b1;
    @(posedge clk) te <= 1'b0;
    repeat (8) @(posedge clk);
    check(bc, 4'h9);
    bdrv <= 1'b1;
    be2 <= 1'b1;
    @(posedge clk) be2 <= 1'b0;
    repeat (8) @(posedge clk);
    check({ic, fl}, {4'h3, 2'h1});
    bobs <= 1'b1;
    oth <= 1'b1;
    repeat (3) @(posedge clk);
    oth <= 1'b0;
    repeat (6) @(posedge clk);
    check({fl, rot}, {2'h3, 2'h3});
    close_out();
  end
  // cut a hang well past the 148 clocks the sequence needs
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    close_out();
  end
endmodule : sysbus_request_attr_error_tb
`default_nettype wire
